// ===== shared/metc_defines.vh
// Constants for the mix/effects transition control block
`ifndef METC_DEFINES_VH
`define METC_DEFINES_VH
`define METC_NBTN 16
`define METC_SRC_W 5
`define METC_POS_W 10
`define METC_POS_MAX 10'h3ff
`define METC_POS_MIN 10'h000
`define METC_STEP_W 10
`define METC_MAP_NONE 5'h1e
`define METC_MAP_BLACK 5'h1f
`define METC_BTN_W 4
`define METC_BG_A_RST 4'h0
`define METC_BG_B_RST 4'h1
`define METC_SEL_RST 5'h01
`define METC_OVER_RST 2'h2
`define METC_DELEG_RST 2'h2
`define METC_LAYER_BGA 0
`define METC_LAYER_BGB 1
`define METC_LAYER_K1 2
`define METC_LAYER_K2 3
`define METC_LAYER_PRI 4
`endif

// ===== design/metc_progress.v
// Transition progress position tracker between two limits
`timescale 1ns/1ps
`include "metc_defines.vh"
module metc_progress (
  input wire clk_in,
  input wire rstn_in,
  input wire run_in,
  input wire cut_in,
  input wire halt_in,
  input wire [`METC_STEP_W-1:0] step_in,
  output reg [`METC_POS_W-1:0] pos_out,
  output wire at_start_out,
  output wire at_end_out,
  output wire mid_out,
  output reg done_out
);
  reg running_r;
  wire [`METC_POS_W:0] sum_w;
  assign sum_w = {1'b0, pos_out} + {1'b0, step_in};
  assign at_start_out = (pos_out == `METC_POS_MIN);
  assign at_end_out = (pos_out == `METC_POS_MAX);
  assign mid_out = !at_start_out && !at_end_out;

  // A run's completion rests one cycle on the end limit, then snaps back to the start; a cut completes at the start
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_out <= `METC_POS_MIN;
      running_r <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (halt_in) begin
        running_r <= 1'b0;
      end else if (cut_in) begin
        pos_out <= `METC_POS_MIN;
        running_r <= 1'b0;
        done_out <= 1'b1;
      end else if (running_r) begin
        if (sum_w >= {1'b0, `METC_POS_MAX}) begin
          pos_out <= `METC_POS_MAX;
          running_r <= 1'b0;
          done_out <= 1'b1;
        end else begin
          pos_out <= sum_w[`METC_POS_W-1:0];
        end
      end else if (at_end_out) begin
        // A start request in this single cycle is dropped; the panel must retry
        pos_out <= `METC_POS_MIN;
      end else if (run_in) begin
        running_r <= 1'b1;
      end
    end
  end
endmodule

// ===== design/metc_top.v
// Mix/effects stage transition control: layers, flip-flop, keys, fade-through-dark
`timescale 1ns/1ps
`include "metc_defines.vh"
module metc_top (
  input wire clk_in,
  input wire rstn_in,
  input wire layered_mode_in,
  input wire [4:0] sel_toggle_in,
  input wire wipe_press_in,
  input wire mix_press_in,
  input wire black_press_in,
  input wire auto_in,
  input wire cut_in,
  input wire [`METC_STEP_W-1:0] step_in,
  input wire a_sel_in,
  input wire [`METC_BTN_W-1:0] a_btn_in,
  input wire b_sel_in,
  input wire [`METC_BTN_W-1:0] b_btn_in,
  input wire [`METC_NBTN*`METC_SRC_W-1:0] button_mapping_menu_in,
  input wire cpu_fail_in,
  input wire reentry_in,
  output reg [4:0] sel_lamp_out,
  output reg [3:0] on_lamp_out,
  output reg [1:0] over_lamp_out,
  output reg layered_lamp_out,
  output reg layered_force_std_out,
  output reg wipe_out,
  output reg mix_out,
  output reg black_lamp_out,
  output reg black_enable_out,
  output reg a_black_lamp_out,
  output reg [`METC_BTN_W-1:0] a_btn_out,
  output reg [`METC_BTN_W-1:0] b_btn_out,
  output reg [1:0] keyer_deleg_out,
  output reg key_bus_deleg_out,
  output reg out_black_out,
  output wire [`METC_POS_W-1:0] pos_out,
  output wire at_start_out,
  output wire at_end_out,
  output wire mid_out
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Leftmost button mapped to black; found flag in the top bit
  function [`METC_BTN_W:0] find_black;
    input [`METC_NBTN*`METC_SRC_W-1:0] map;
    integer i;
    reg [`METC_BTN_W:0] res;
    begin
      res = {(`METC_BTN_W+1){1'b0}};
      for (i = `METC_NBTN-1; i >= 0; i = i - 1) begin
        if (map[i*`METC_SRC_W +: `METC_SRC_W] == `METC_MAP_BLACK) begin
          res = {1'b1, i[`METC_BTN_W-1:0]};
        end
      end
      find_black = res;
    end
  endfunction

  // Standard mode has no second background layer, so its selector is inert
  function [4:0] sel_mask;
    input layered;
    begin
      sel_mask = layered ? 5'h1f : 5'h1d;
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_TO_BLK = 3'b010;
  localparam [2:0] ST_AT_BLK = 3'b100;

  reg [2:0] ftb_r;
  reg [2:0] ftb_nxt;
  reg [3:0] key_on_r;
  reg halt_r;
  wire [`METC_BTN_W:0] blk_w;
  wire [4:0] eff_sel_w;
  wire [4:0] tog_w;
  wire done_w;
  wire run_w;
  wire a_abort_w;

  assign blk_w = find_black(button_mapping_menu_in);
  // A bgB lamp left lit from layered mode must not drive a standard transition
  assign eff_sel_w = sel_lamp_out & sel_mask(layered_mode_in);
  assign tog_w = sel_toggle_in & sel_mask(layered_mode_in);
  assign run_w = auto_in;
  assign a_abort_w = a_sel_in && (ftb_r == ST_AT_BLK);

  metc_progress u_prog (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .run_in(run_w),
    .cut_in(cut_in),
    .halt_in(halt_r),
    .step_in(step_in),
    .pos_out(pos_out),
    .at_start_out(at_start_out),
    .at_end_out(at_end_out),
    .mid_out(mid_out),
    .done_out(done_w)
  );

  // ------------------------------------------------------------
  // Fade-through-dark sequencer
  // ------------------------------------------------------------
  always @* begin
    ftb_nxt = ftb_r;
    case (ftb_r)
      ST_IDLE: begin
        ftb_nxt = ST_IDLE;
      end
      ST_TO_BLK: begin
        if (done_w) begin
          ftb_nxt = ST_AT_BLK;
        end
      end
      ST_AT_BLK: begin
        if (done_w) begin
          ftb_nxt = ST_IDLE;
        end
      end
      default: begin
        ftb_nxt = ST_IDLE;
      end
    endcase
    // Disarm or abort wins over sequence progress
    if (!black_lamp_out || a_abort_w || !blk_w[`METC_BTN_W]) begin
      ftb_nxt = ST_IDLE;
    end else if (ftb_r == ST_IDLE) begin
      ftb_nxt = ST_TO_BLK;
    end
  end

  // ------------------------------------------------------------
  // Panel and layer state
  // ------------------------------------------------------------
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ftb_r <= ST_IDLE;
      key_on_r <= 4'h0;
      halt_r <= 1'b0;
      sel_lamp_out <= `METC_SEL_RST;
      on_lamp_out <= 4'h0;
      over_lamp_out <= `METC_OVER_RST;
      layered_lamp_out <= 1'b0;
      layered_force_std_out <= 1'b0;
      wipe_out <= 1'b0;
      mix_out <= 1'b1;
      black_lamp_out <= 1'b0;
      black_enable_out <= 1'b0;
      a_black_lamp_out <= 1'b0;
      a_btn_out <= `METC_BG_A_RST;
      b_btn_out <= `METC_BG_B_RST;
      keyer_deleg_out <= `METC_DELEG_RST;
      key_bus_deleg_out <= 1'b0;
      out_black_out <= 1'b0;
    end else begin
      ftb_r <= ftb_nxt;
      halt_r <= 1'b0;
      layered_force_std_out <= 1'b0;

      // ------------------------------------------------------------
      // Selectors and keyer delegation
      // ------------------------------------------------------------
      // Any combination of selectors may be toggled in one cycle; bgB toggles only in layered mode
      sel_lamp_out <= sel_lamp_out ^ tog_w;
      if (sel_toggle_in[`METC_LAYER_K1] && !sel_lamp_out[`METC_LAYER_K1]) begin
        keyer_deleg_out <= 2'd2;
        key_bus_deleg_out <= 1'b0;
      end
      if (sel_toggle_in[`METC_LAYER_K2] && !sel_lamp_out[`METC_LAYER_K2]) begin
        keyer_deleg_out <= 2'd3;
        key_bus_deleg_out <= 1'b1;
      end
      // Background layers route only the keyer controls, never the key bus
      if (layered_mode_in && sel_toggle_in[`METC_LAYER_BGA]) begin
        keyer_deleg_out <= 2'd0;
      end
      if (layered_mode_in && sel_toggle_in[`METC_LAYER_BGB]) begin
        keyer_deleg_out <= 2'd1;
      end

      // ------------------------------------------------------------
      // Transition type and fade-through-dark arming
      // ------------------------------------------------------------
      if (wipe_press_in) begin
        wipe_out <= 1'b1;
        mix_out <= 1'b0;
      end else if (mix_press_in) begin
        mix_out <= 1'b1;
        wipe_out <= 1'b0;
      end
      // Losing the black mapping also disarms, as nothing is left to fade to
      black_enable_out <= blk_w[`METC_BTN_W];
      if (black_press_in && blk_w[`METC_BTN_W]) begin
        black_lamp_out <= !black_lamp_out;
        if (black_lamp_out && ftb_r == ST_AT_BLK && at_start_out) begin
          out_black_out <= 1'b0;
        end else if (black_lamp_out && mid_out) begin
          halt_r <= 1'b1;
        end
      end else if (!blk_w[`METC_BTN_W]) begin
        black_lamp_out <= 1'b0;
      end
      layered_lamp_out <= layered_mode_in;
      // Background layers start on air; a layered transition takes them off
      if (layered_mode_in) begin
        on_lamp_out <= {key_on_r[3:2], ~key_on_r[1:0]};
      end else begin
        on_lamp_out <= {key_on_r[3:2], 2'h0};
      end
      if (b_sel_in) begin
        b_btn_out <= b_btn_in;
      end

      // ------------------------------------------------------------
      // Crosspoints, abort and fallback
      // ------------------------------------------------------------
      // At black limit the first bus shows the black crosspoint
      a_black_lamp_out <= (ftb_r == ST_AT_BLK);
      if (a_abort_w) begin
        black_lamp_out <= 1'b0;
        // Keys drop so the picked source goes out as a full raster
        key_on_r <= 4'h0;
        a_btn_out <= a_btn_in;
        out_black_out <= 1'b0;
        layered_force_std_out <= layered_mode_in;
      end else if (a_sel_in) begin
        a_btn_out <= a_btn_in;
      end else if (cpu_fail_in && reentry_in) begin
        // Falls back to button zero, the leftmost, when no black mapping exists
        a_btn_out <= blk_w[`METC_BTN_W-1:0];
        b_btn_out <= blk_w[`METC_BTN_W-1:0];
      end

      // ------------------------------------------------------------
      // Transition completion
      // ------------------------------------------------------------
      if (done_w && !a_abort_w) begin
        if (ftb_r == ST_TO_BLK) begin
          // The output goes dark and bus A takes the black crosspoint here; keys wait for stage two and bus B is left unchanged
          out_black_out <= 1'b1;
          a_btn_out <= blk_w[`METC_BTN_W-1:0];
        end else begin
          out_black_out <= 1'b0;
          if (ftb_r == ST_AT_BLK) begin
            black_lamp_out <= 1'b0;
          end
          if (!layered_mode_in && eff_sel_w[`METC_LAYER_BGA] && ftb_r != ST_AT_BLK) begin
            a_btn_out <= b_btn_out;
            b_btn_out <= a_btn_out;
          end else if (!layered_mode_in && ftb_r == ST_AT_BLK) begin
            a_btn_out <= b_btn_out;
          end
          if (eff_sel_w[`METC_LAYER_K1]) begin
            key_on_r[2] <= !key_on_r[2];
          end
          if (eff_sel_w[`METC_LAYER_K2]) begin
            key_on_r[3] <= !key_on_r[3];
          end
          if (layered_mode_in && eff_sel_w[`METC_LAYER_BGA]) begin
            key_on_r[0] <= !key_on_r[0];
          end
          if (layered_mode_in && eff_sel_w[`METC_LAYER_BGB]) begin
            key_on_r[1] <= !key_on_r[1];
          end
          if (eff_sel_w[`METC_LAYER_PRI]) begin
            over_lamp_out <= ~over_lamp_out;
          end
        end
      end
    end
  end
endmodule

// ===== sim/metc_props.sv
// Assertion checker on the transition control stage ports
`timescale 1ns/1ps
module metc_props (
  input wire clk_in,
  input wire rstn_in,
  input wire layered_mode_in,
  input wire [4:0] sel_toggle_in,
  input wire black_press_in,
  input wire cut_in,
  input wire a_sel_in,
  input wire b_sel_in,
  input wire [4:0] sel_lamp_out,
  input wire [3:0] on_lamp_out,
  input wire layered_lamp_out,
  input wire wipe_out,
  input wire mix_out,
  input wire black_lamp_out,
  input wire black_enable_out,
  input wire a_black_lamp_out,
  input wire [3:0] a_btn_out,
  input wire [3:0] b_btn_out,
  input wire [1:0] keyer_deleg_out,
  input wire key_bus_deleg_out,
  input wire out_black_out,
  input wire at_start_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // A cut from rest with no bus pick or arm racing it
  sequence s_cut;
    cut_in && !black_press_in && !a_sel_in && !b_sel_in && at_start_out ##1
      !cut_in && !black_press_in && !a_sel_in && !b_sel_in;
  endsequence
  sequence s_bg_cut;
    sel_lamp_out[0] && !layered_mode_in && !black_lamp_out && !out_black_out ##0 s_cut;
  endsequence
  sequence s_dark_cut;
    black_lamp_out && $past(black_lamp_out) && !out_black_out ##0 s_cut;
  endsequence
  a_wipe_mix_excl: assert property (wipe_out != mix_out)
    else $error("wipe and mix clash");
  a_std_lamps_dark: assert property (
    !layered_mode_in |=> !layered_lamp_out && on_lamp_out[1:0] == 2'b00)
    else $error("standard lamps lit");
  a_key_toggle: assert property (
    sel_toggle_in[2] |=> sel_lamp_out[2] != $past(sel_lamp_out[2]))
    else $error("key selector not toggled");
  a_key_deleg: assert property (
    sel_toggle_in == 5'h04 && !sel_lamp_out[2] |=> keyer_deleg_out == 2'd2 && !key_bus_deleg_out)
    else $error("key delegation wrong");
  a_bg_deleg: assert property (
    layered_mode_in && sel_toggle_in == 5'h02 && !sel_lamp_out[1]
      |=> keyer_deleg_out == 2'd1 && $stable(key_bus_deleg_out))
    else $error("background delegation wrong");
  a_black_refused: assert property (
    black_press_in && !black_enable_out && !black_lamp_out |=> !black_lamp_out)
    else $error("armed without black");
  a_bg_flip: assert property (
    s_bg_cut |=> a_btn_out == $past(b_btn_out, 2) && b_btn_out == $past(a_btn_out, 2))
    else $error("buses not exchanged");
  a_dark_steps: assert property (s_dark_cut |=> out_black_out ##1 a_black_lamp_out)
    else $error("black stage wrong");
endmodule
bind metc_top metc_props u_props (.clk_in(clk_in), .rstn_in(rstn_in),
  .layered_mode_in(layered_mode_in), .sel_toggle_in(sel_toggle_in),
  .black_press_in(black_press_in), .cut_in(cut_in), .a_sel_in(a_sel_in), .b_sel_in(b_sel_in),
  .sel_lamp_out(sel_lamp_out), .on_lamp_out(on_lamp_out), .layered_lamp_out(layered_lamp_out),
  .wipe_out(wipe_out), .mix_out(mix_out), .black_lamp_out(black_lamp_out),
  .black_enable_out(black_enable_out), .a_black_lamp_out(a_black_lamp_out),
  .a_btn_out(a_btn_out), .b_btn_out(b_btn_out), .keyer_deleg_out(keyer_deleg_out),
  .key_bus_deleg_out(key_bus_deleg_out), .out_black_out(out_black_out),
  .at_start_out(at_start_out));

// ===== sim/metc_panel.sv
// Operator panel model: button pulses and bus picks
`timescale 1ns/1ps
module metc_panel (
  input wire clk_in,
  output reg layered_out = 1'b0,
  output reg [9:0] btn_out = 10'h000,
  output reg a_sel_out = 1'b0,
  output reg [3:0] a_idx_out = 4'h5,
  output reg b_sel_out = 1'b0,
  output reg [3:0] b_idx_out = 4'ha
);
  task push(input [9:0] b);
    begin
      @(negedge clk_in) btn_out = b;
      @(negedge clk_in) btn_out = 10'h000;
    end
  endtask
  // Released index lines show the inverse, so a stale index never looks valid
  task pick(input bus_b, input [3:0] idx);
    begin
      @(negedge clk_in) {a_sel_out, b_sel_out} = {!bus_b, bus_b};
      {a_idx_out, b_idx_out} = {idx, idx};
      @(negedge clk_in) {a_sel_out, b_sel_out} = 2'b00;
      {a_idx_out, b_idx_out} = {~idx, ~idx};
    end
  endtask
endmodule

// ===== sim/mix_effect_transition_control_test.sv
// Self-checking bench for the mix/effects transition control stage
`timescale 1ns/1ps
`include "metc_defines.vh"
module mix_effect_transition_control_test;
  reg clk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg cpu_fail_in = 1'b0;
  reg reentry_in = 1'b0;
  reg [9:0] step_in = 10'h100;
  reg [79:0] button_mapping_menu_in = 80'h0;
  wire layered_mode_in, wipe_press_in, mix_press_in, black_press_in, auto_in, cut_in;
  wire a_sel_in, b_sel_in, layered_lamp_out, layered_force_std_out, wipe_out, mix_out;
  wire black_lamp_out, black_enable_out, a_black_lamp_out, key_bus_deleg_out;
  wire out_black_out, at_start_out, at_end_out, mid_out;
  wire [4:0] sel_toggle_in, sel_lamp_out;
  wire [3:0] on_lamp_out, a_btn_in, b_btn_in, a_btn_out, b_btn_out;
  wire [1:0] over_lamp_out, keyer_deleg_out;
  wire [9:0] pos_out;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer i;
  reg [4:0] e, m;
  reg [3:0] k, x;
  reg [1:0] seen;
  metc_panel P (.clk_in(clk_in), .layered_out(layered_mode_in), .a_sel_out(a_sel_in),
    .btn_out({sel_toggle_in, wipe_press_in, mix_press_in, black_press_in, auto_in, cut_in}),
    .a_idx_out(a_btn_in), .b_sel_out(b_sel_in), .b_idx_out(b_btn_in));
  metc_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .layered_mode_in(layered_mode_in),
    .sel_toggle_in(sel_toggle_in), .wipe_press_in(wipe_press_in), .mix_press_in(mix_press_in),
    .black_press_in(black_press_in), .auto_in(auto_in), .cut_in(cut_in), .step_in(step_in),
    .a_sel_in(a_sel_in), .a_btn_in(a_btn_in), .b_sel_in(b_sel_in), .b_btn_in(b_btn_in),
    .button_mapping_menu_in(button_mapping_menu_in), .cpu_fail_in(cpu_fail_in),
    .reentry_in(reentry_in), .sel_lamp_out(sel_lamp_out), .on_lamp_out(on_lamp_out),
    .over_lamp_out(over_lamp_out), .layered_lamp_out(layered_lamp_out),
    .layered_force_std_out(layered_force_std_out), .wipe_out(wipe_out), .mix_out(mix_out),
    .black_lamp_out(black_lamp_out), .black_enable_out(black_enable_out),
    .a_black_lamp_out(a_black_lamp_out), .a_btn_out(a_btn_out), .b_btn_out(b_btn_out),
    .keyer_deleg_out(keyer_deleg_out), .key_bus_deleg_out(key_bus_deleg_out),
    .out_black_out(out_black_out), .pos_out(pos_out), .at_start_out(at_start_out),
    .at_end_out(at_end_out), .mid_out(mid_out));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      stop_test;
    end
  end
  // Standard mode never lets the second background selector through
  function [4:0] toggled(input [4:0] cur, input [4:0] msk, input lay);
    toggled = cur ^ (msk & (lay ? 5'h1f : 5'h1d));
  endfunction
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [47:0] what, input [15:0] ex, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== ex) begin
        bad_count = bad_count + 1;
        $display("BAD %0s expected %h seen %h", what, ex, got);
      end
    end
  endtask
  task act(input [9:0] b);
    begin
      P.push(b);
      repeat (4) @(negedge clk_in);
    end
  endtask
  // Controller loss during re-entry: both buses fall back to the black crosspoint, or to button zero when none is mapped
  task drop_reentry(input [3:0] ex);
    begin
      cpu_fail_in = 1'b1;
      reentry_in = 1'b1;
      @(negedge clk_in);
      cpu_fail_in = 1'b0;
      reentry_in = 1'b0;
      @(negedge clk_in);
      chk("fail", {ex, ex}, {a_btn_out, b_btn_out});
    end
  endtask
  initial begin
    i = $urandom(40);
    for (i = 0; i < 16; i = i + 1)
      button_mapping_menu_in[i*5 +: 5] = 5'($urandom % 16);
    k = 4'($urandom % 12 + 2);
    button_mapping_menu_in[k*5 +: 5] = `METC_MAP_BLACK;
    button_mapping_menu_in[k*5-5 +: 5] = `METC_MAP_NONE;
    button_mapping_menu_in[75 +: 5] = `METC_MAP_BLACK;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    chk("reset", {5'h01, 2'b10, 2'b10, 2'd2, 4'h1},
      {sel_lamp_out, over_lamp_out, mix_out, wipe_out, keyer_deleg_out, b_btn_out});
    act(10'h010);
    chk("wipe", 2'b10, {wipe_out, mix_out});
    act(10'h018);
    chk("both", 2'b10, {wipe_out, mix_out});
    act(10'h008);
    chk("mix", 2'b01, {wipe_out, mix_out});
    $display("test type done");
    e = 5'h01;
    for (i = 0; i < 9; i = i + 1) begin
      m = (i == 0) ? 5'h04 : 5'($urandom) & 5'h1e;
      act({m, 5'h00});
      e = toggled(e, m, 1'b0);
      chk("select", e, sel_lamp_out);
    end
    act({e & 5'h1c, 5'h00});
    P.layered_out = 1'b1;
    act(10'h040);
    chk("layer", {1'b1, 2'd1, 3'b111},
      {sel_lamp_out[1], keyer_deleg_out, layered_lamp_out, on_lamp_out[1:0]});
    act(10'h040);
    P.layered_out = 1'b0;
    act(10'h080);
    $display("test select done");
    x = 4'($urandom % 15);
    P.pick(1'b0, x);
    P.pick(1'b1, x + 4'h1);
    act(10'h001);
    chk("cut", {x + 4'h1, x, 1'b1}, {a_btn_out, b_btn_out, on_lamp_out[2]});
    P.push(10'h002);
    seen = 2'b00;
    for (i = 0; i < 12; i = i + 1) begin
      @(negedge clk_in);
      seen = seen | {at_end_out, mid_out};
    end
    chk("auto", {2'b11, x, x + 4'h1, 1'b0},
      {seen, a_btn_out, b_btn_out, on_lamp_out[2]});
    act(10'h080);
    $display("test flip done");
    act(10'h004);
    act(10'h001);
    chk("dark", {3'b111, k},
      {out_black_out, a_black_lamp_out, black_lamp_out, a_btn_out});
    act(10'h001);
    chk("light", {2'b00, x + 4'h1}, {out_black_out, black_lamp_out, a_btn_out});
    act(10'h004);
    act(10'h001);
    act(10'h004);
    chk("disarm", 2'b00, {out_black_out, black_lamp_out});
    act(10'h100);
    act(10'h001);
    chk("key2", 1'b1, on_lamp_out[3]);
    act(10'h004);
    act(10'h001);
    P.layered_out = 1'b1;
    P.pick(1'b0, x);
    chk("force", 1'b1, layered_force_std_out);
    P.layered_out = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("abort", {2'b00, x, 2'b00},
      {black_lamp_out, out_black_out, a_btn_out, on_lamp_out[3:2]});
    drop_reentry(k);
    button_mapping_menu_in = 80'h0;
    act(10'h004);
    chk("noblk", 2'b00, {black_enable_out, black_lamp_out});
    $display("test black done");
    drop_reentry(4'h0);
    act(10'h200);
    act(10'h001);
    chk("over", 2'b01, over_lamp_out);
    $display("test fallback done");
    stop_test;
  end
endmodule
